// File: enable_word_if.sv
// Carrier between the register decoder and one set-enable word.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface enable_word_if;
  logic        wr_set;
  logic [31:0] wdata;
  logic [31:0] state;

  modport ctrl (output wr_set, output wdata, input state);
  modport bank (input wr_set, input wdata, output state);
endinterface

// File: irq_enable_pkg.sv
// Constants shared by the interrupt set-enable bank and its register port.
// Assumes a 32-bit register port with byte addresses on a plain strobe bus.
package irq_enable_pkg;
  localparam int          DATA_W      = 32;
  localparam int          ADDR_W      = 8;
  localparam int          WORD_COUNT  = 2;
  // Register byte offsets
  localparam logic [7:0]  OFFS_WORD0  = 8'h00;
  localparam logic [7:0]  OFFS_WORD1  = 8'h04;
  // Bit positions that hold a real enable; others are unassigned
  localparam logic [31:0] MASK_WORD0  = 32'h7FFF_C0FF;
  localparam logic [31:0] MASK_WORD1  = 32'h0CFF_FFEF;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] READ_IDLE   = 32'h0000_0000;
endpackage

// File: irq_enable_word.sv
// One 32-bit word of write-one-to-set interrupt enables.
// Assumes the write strobe is one cycle long and qualified by the decoder.
`timescale 1ns/1ps
module irq_enable_word #(
  parameter logic [31:0] IMPL_MASK = 32'hFFFF_FFFF
) (
  input  wire logic   i_sys_clk,
  input  wire logic   i_rst_n,
  enable_word_if.bank port
);
  logic [31:0] state;
  logic [31:0] next_state;

  // Ones set, zeros keep; unassigned positions never store
  always_comb
  begin
    next_state = state;
    if (port.wr_set)
    begin
      next_state = state | (port.wdata & IMPL_MASK); // see R1 see R2
    end
  end

  // All enables cleared by reset
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= irq_enable_pkg::RESET_VALUE; // see R6
    end
    else
    begin
      state <= next_state;
    end
  end

  assign port.state = state;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_set_write;
    port.wr_set && ((port.wdata & IMPL_MASK) != 32'h0000_0000);
  endsequence

  // Each step looks back to the written word itself, not to later bus data
  chk_set_bits_stick: assert property ( // see R1
    s_set_write |=> ((state & $past(port.wdata & IMPL_MASK, 1))
                     == $past(port.wdata & IMPL_MASK, 1))
    ##1 ((state & $past(port.wdata & IMPL_MASK, 2))
         == $past(port.wdata & IMPL_MASK, 2))
    ##1 ((state & $past(port.wdata & IMPL_MASK, 3))
         == $past(port.wdata & IMPL_MASK, 3)))
    else $error("written one did not enable and stay enabled");

  chk_no_clear_path: assert property ( // see R2
    ((state & $past(state)) == $past(state)))
    else $error("an enable was cleared without reset");

  chk_idle_holds: assert property ( // see R2
    !port.wr_set |=> $stable(state))
    else $error("enable state changed without a write");

  chk_unassigned_zero: assert property ( // see R4 see R5
    (state & ~IMPL_MASK) == 32'h0000_0000)
    else $error("unassigned enable position became set");
endmodule

// File: irq_set_enable_bank.sv
// Top of the interrupt set-enable bank: register decode, read path, enables out.
// Assumes a single-cycle strobe master that never asserts read and write together.
// Operation
// R1 - Writing one to an enable bit enables its interrupt and keeps it enabled.
// R2 - Writing zero leaves an enable unchanged; writes never clear enables.
// R3 - Reading returns current enable state, one enabled, zero disabled.
// R4 - Word 0 bits 30..14 and 7..0 map to interrupts 30..14 and 7..0.
// R5 - Word 1 bits 27..26, 23..5, 3..0 map to interrupts 59..58, 55..37, 35..32.
// R6 - Software writes zero to unassigned bits; all enables clear after reset.
`timescale 1ns/1ps
module irq_set_enable_bank (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic      [63:0] o_irq_enable
);
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [63:0] word_state;

  // Refuse a build the decoder cannot serve: two words of 32 bits,
  // byte offsets that fit the address port and differ from each other
  if ((irq_enable_pkg::WORD_COUNT != 2) || (irq_enable_pkg::DATA_W != 32))
  begin : g_bad_shape
    $error("bank supports exactly two 32-bit enable words");
  end
  if (irq_enable_pkg::ADDR_W != 8)
  begin : g_bad_addr
    $error("address port width must match the offsets");
  end
  if (irq_enable_pkg::OFFS_WORD0 == irq_enable_pkg::OFFS_WORD1)
  begin : g_bad_offs
    $error("the two enable words need distinct offsets");
  end

  // One enable word per register; interrupt number is word*32 + bit
  for (genvar w = 0; w < irq_enable_pkg::WORD_COUNT; w++)
  begin : g_word
    enable_word_if wif ();
    localparam logic [7:0]  OFFS = (w == 0) ? irq_enable_pkg::OFFS_WORD0
                                            : irq_enable_pkg::OFFS_WORD1;
    localparam logic [31:0] MASK = (w == 0) ? irq_enable_pkg::MASK_WORD0
                                            : irq_enable_pkg::MASK_WORD1;
    // Write decode for this word
    assign wif.wr_set = i_wr && (i_addr == OFFS);
    assign wif.wdata  = i_wdata;
    assign word_state[w*32 +: 32] = wif.state; // see R4 see R5

    irq_enable_word #(
      .IMPL_MASK (MASK)
    ) u_word (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .port      (wif.bank)
    );
  end

  // Read mux; unmapped offsets and idle cycles return zero
  always_comb
  begin
    next_rdata = irq_enable_pkg::READ_IDLE;
    if (i_rd && (i_addr == irq_enable_pkg::OFFS_WORD0))
    begin
      next_rdata = word_state[31:0]; // see R3
    end
    else if (i_rd && (i_addr == irq_enable_pkg::OFFS_WORD1))
    begin
      next_rdata = word_state[63:32]; // see R3
    end
  end

  // Read data held for exactly the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata <= irq_enable_pkg::READ_IDLE;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  assign o_rdata      = rdata;
  assign o_irq_enable = word_state; // Flops live in the word modules

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_read0;
    i_rd && (i_addr == irq_enable_pkg::OFFS_WORD0);
  endsequence

  sequence s_read1;
    i_rd && (i_addr == irq_enable_pkg::OFFS_WORD1);
  endsequence

  chk_read_word0: assert property ( // see R3
    s_read0 |=> (o_rdata == $past(o_irq_enable[31:0])))
    else $error("word 0 read did not return enable state");

  chk_read_word1: assert property ( // see R3
    s_read1 |=> (o_rdata == $past(o_irq_enable[63:32])))
    else $error("word 1 read did not return enable state");

  chk_write_maps: assert property ( // see R4 see R5
    (i_wr && (i_addr == irq_enable_pkg::OFFS_WORD1) && i_wdata[27])
    |=> o_irq_enable[59] ##1 o_irq_enable[59])
    else $error("interrupt 59 not enabled by word 1 bit 27");

  chk_read_idle_zero: assert property ( // see R3
    !i_rd |=> (o_rdata == 32'h0000_0000))
    else $error("read data not zero outside read answer");

  // Offsets that hold no enable word
  sequence s_read_unmapped;
    i_rd && (i_addr != irq_enable_pkg::OFFS_WORD0)
         && (i_addr != irq_enable_pkg::OFFS_WORD1);
  endsequence

  sequence s_write_unmapped;
    i_wr && (i_addr != irq_enable_pkg::OFFS_WORD0)
         && (i_addr != irq_enable_pkg::OFFS_WORD1);
  endsequence

  sequence s_write0;
    i_wr && (i_addr == irq_enable_pkg::OFFS_WORD0);
  endsequence

  sequence s_write1;
    i_wr && (i_addr == irq_enable_pkg::OFFS_WORD1);
  endsequence

  // A read of a hole answers zero rather than aliasing a real word
  chk_read_hole_zero: assert property ( // see R3
    s_read_unmapped |=> (o_rdata == 32'h0000_0000))
    else $error("read of unmapped offset returned data");

  // A write to a hole must not reach either word
  chk_write_hole_inert: assert property ( // see R4 see R5
    s_write_unmapped |=> $stable(o_irq_enable))
    else $error("write to unmapped offset changed enables");

  // Without a write the whole bank holds still
  chk_bank_holds: assert property ( // see R2
    !i_wr |=> $stable(o_irq_enable))
    else $error("enables moved without a write");

  // No bit of the bank ever falls while reset is off
  chk_bank_no_clear: assert property ( // see R2
    ((o_irq_enable & $past(o_irq_enable)) == $past(o_irq_enable)))
    else $error("an interrupt enable was cleared by a write");

  // Writing one word leaves the other word alone
  chk_word0_write_local: assert property ( // see R4
    s_write0 |=> $stable(o_irq_enable[63:32]))
    else $error("word 0 write disturbed word 1 enables");

  chk_word1_write_local: assert property ( // see R5
    s_write1 |=> $stable(o_irq_enable[31:0]))
    else $error("word 1 write disturbed word 0 enables");

  // Read data never shows a hole as set, whatever was written there
  chk_read0_masked: assert property ( // see R3 see R4
    s_read0 |=> ((o_rdata & ~irq_enable_pkg::MASK_WORD0) == 32'h0000_0000))
    else $error("word 0 read showed an unassigned bit");

  chk_read1_masked: assert property ( // see R3 see R5
    s_read1 |=> ((o_rdata & ~irq_enable_pkg::MASK_WORD1) == 32'h0000_0000))
    else $error("word 1 read showed an unassigned bit");

  // Read straight after a write must already show the new ones
  chk_read_after_write: assert property ( // see R1 see R3
    s_write0 ##1 s_read0
    |=> ((o_rdata & $past(i_wdata & irq_enable_pkg::MASK_WORD0, 2))
         == $past(i_wdata & irq_enable_pkg::MASK_WORD0, 2)))
    else $error("read after write missed freshly set enables");

  chk_read_after_write1: assert property ( // see R1 see R3
    s_write1 ##1 s_read1
    |=> ((o_rdata & $past(i_wdata & irq_enable_pkg::MASK_WORD1, 2))
         == $past(i_wdata & irq_enable_pkg::MASK_WORD1, 2)))
    else $error("read after word 1 write missed new enables");

  // Bit-level map: interrupt n follows bit n mod 32 of word n / 32, and the
  // holes in each word stay dark whatever software writes there
  for (genvar n = 0; n < irq_enable_pkg::WORD_COUNT * 32; n++)
  begin : g_bit_chk
    localparam int          WORD = n / 32;
    localparam int          POS  = n % 32;
    localparam logic [7:0]  OFFS = (WORD == 0) ? irq_enable_pkg::OFFS_WORD0
                                               : irq_enable_pkg::OFFS_WORD1;
    localparam logic [31:0] MASK = (WORD == 0) ? irq_enable_pkg::MASK_WORD0
                                               : irq_enable_pkg::MASK_WORD1;
    if (MASK[POS])
    begin : g_live
      chk_bit_sets: assert property ( // see R4 see R5
        (i_wr && (i_addr == OFFS) && i_wdata[POS]) |=> o_irq_enable[n])
        else $error("mapped enable bit did not set on write");

      chk_bit_sticks: assert property ( // see R1
        o_irq_enable[n] |=> o_irq_enable[n])
        else $error("enabled interrupt dropped without reset");
    end
    else
    begin : g_dead
      chk_bit_dark: assert property ( // see R4 see R5
        !o_irq_enable[n])
        else $error("unassigned interrupt enable became set");
    end
  end
endmodule

// File: tb_irq_set_enable_bank.sv
// Self-checking bench for the interrupt set-enable bank.
// Assumes the bank's package and the design files are compiled first.
`timescale 1ns/1ps
module tb_irq_set_enable_bank;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n   = 1'b0;
  logic [7:0]  i_addr    = 8'h00;
  logic [31:0] i_wdata   = 32'h0000_0000;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic [31:0] o_rdata;
  logic [63:0] o_irq_enable;
  int          errors    = 0;
  int          num_checks = 0;
  logic [31:0] d;

  irq_set_enable_bank irq_set_enable_bank_inst (
    .i_sys_clk    (i_sys_clk),
    .i_rst_n      (i_rst_n),
    .i_addr       (i_addr),
    .i_wdata      (i_wdata),
    .i_wr         (i_wr),
    .i_rd         (i_rd),
    .o_rdata      (o_rdata),
    .o_irq_enable (o_irq_enable)
  );

  // 50 MHz system clock
  always #10 i_sys_clk = ~i_sys_clk;

  task automatic check(input string n, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // One-cycle strobes; values change only right after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_sys_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    @(negedge i_sys_clk);
  endtask

  // Data sampled mid-cycle, in the only cycle it is valid
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    d = o_rdata;
  endtask

  task automatic t_reset;
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    check("enables in reset", o_irq_enable, 64'h0);
    @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(irq_enable_pkg::OFFS_WORD0);
    check("word0 after reset", d, 32'h0);
    rd(irq_enable_pkg::OFFS_WORD1);
    check("word1 after reset", d, 32'h0);
    wr(irq_enable_pkg::OFFS_WORD0, 32'h0000_0001);
    check("first write after reset", o_irq_enable, 64'h1);
    $display("test reset done");
  endtask

  task automatic t_word0;
    wr(irq_enable_pkg::OFFS_WORD0, irq_enable_pkg::MASK_WORD0);
    check("word0 enables", o_irq_enable, {32'h0, irq_enable_pkg::MASK_WORD0});
    rd(irq_enable_pkg::OFFS_WORD0);
    check("word0 read", d, irq_enable_pkg::MASK_WORD0);
    @(negedge i_sys_clk);
    check("read data drops", o_rdata, 32'h0);
    wr(irq_enable_pkg::OFFS_WORD0, 32'h0);
    rd(irq_enable_pkg::OFFS_WORD0);
    check("zero keeps word0", d, irq_enable_pkg::MASK_WORD0);
    $display("test word0 done");
  endtask

  task automatic t_word1;
    wr(irq_enable_pkg::OFFS_WORD1, 32'h0800_0000);
    check("interrupt 59", o_irq_enable[63:32], 32'h0800_0000);
    wr(irq_enable_pkg::OFFS_WORD1, 32'h0400_0000);
    rd(irq_enable_pkg::OFFS_WORD1);
    check("58 and 59 kept", d, 32'h0C00_0000);
    wr(irq_enable_pkg::OFFS_WORD1, irq_enable_pkg::MASK_WORD1);
    check("word1 enables", o_irq_enable[63:32], irq_enable_pkg::MASK_WORD1);
    // Unmapped offset must neither store nor answer
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h08);
    check("unmapped read", d, 32'h0);
    check("all enables", o_irq_enable,
          {irq_enable_pkg::MASK_WORD1, irq_enable_pkg::MASK_WORD0});
    $display("test word1 done");
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog well past the few dozen cycles the tests need
  initial
  begin
    #40000;
    errors++;
    conclude();
  end

  // Main sequence; a second reset proves enables clear mid-run
  initial
  begin
    t_reset();
    t_word0();
    t_word1();
    t_reset();
    conclude();
  end
endmodule
